//--- rtl/psi_consts.svh
// Function
// [RULE1] three-bit code selects standard, left or right framing
// [RULE2] bit 5 set sends the right word first
// [RULE3] bits 4:3 give 64, 48 or 32 clocks
// [RULE4] bit 2 set sends least significant bit first
// [RULE5] bit 1 picks word select level of first word
// [RULE6] bit 0 swaps launch and capture clock edges
// [RULE7] source drives all three link lines continuously
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH
// =====================================================
// device register map
`define PSI_REG_FORMAT     8'h35
`define PSI_REG_TIMING     8'h36
`define PSI_RST_FORMAT     8'h01
`define PSI_RST_TIMING     8'h01
// =====================================================
// field positions
`define PSI_FMT_MSB        2
`define PSI_RIGHTFIRST_BIT 5
`define PSI_FSIZE_MSB      4
`define PSI_FSIZE_LSB      3
`define PSI_LSBFIRST_BIT   2
`define PSI_WSPOL_BIT      1
`define PSI_SCKPOL_BIT     0
// =====================================================
// frame size codes and word limits
`define PSI_FSIZE_64       2'h0
`define PSI_FSIZE_48       2'h1
`define PSI_FSIZE_32       2'h2
`define PSI_WORD_MAX       6'h18
// =====================================================
// controller apb map
`define PSI_APB_CFG        8'h00
`define PSI_APB_LEFT       8'h04
`define PSI_APB_RIGHT      8'h08
`define PSI_APB_STAT       8'h0c
`define PSI_CFG_EN_BIT     16
`endif

//--- rtl/psi_pkg.sv
`default_nettype none
package psi_pkg;
   // word framing codes
   typedef enum logic [2:0] {
      PSI_FMT_I2S  = 3'b000,
      PSI_FMT_LJ   = 3'b001,
      PSI_FMT_RJ16 = 3'b100,
      PSI_FMT_RJ20 = 3'b101,
      PSI_FMT_RJ18 = 3'b110,
      PSI_FMT_RJ24 = 3'b111
   } psi_fmt_e;

   // geometry of one half frame
   typedef struct packed {
      logic [5:0] half;   // clocks per word select level
      logic [5:0] start;  // first data clock in the half
      logic [5:0] width;  // data bits per word
   } psi_geom_s;

   // shared by both ends so they frame alike
   function automatic psi_geom_s psi_geom(input logic [2:0] fmt,
                                          input logic [1:0] fs);
      psi_geom_s g;
      g.half  = (fs == 2'h1) ? 6'h18 : (fs == 2'h2) ? 6'h10 : 6'h20;
      g.start = 6'h00;
      case (fmt)
         3'b100: g.width = 6'h10;
         3'b101: g.width = 6'h14;
         3'b110: g.width = 6'h12;
         3'b111: g.width = 6'h18;
         default: g.width = (g.half > 6'h18) ? 6'h18 : g.half;
      endcase
      // a word longer than its half is cut to the half
      if (g.width > g.half) begin
         g.width = g.half;
      end
      if (fmt[2]) begin
         g.start = g.half - g.width;
      end else if (fmt[0] == 1'b0) begin
         g.start = 6'h01;
      end
      return g;
   endfunction : psi_geom
endpackage : psi_pkg
`default_nettype wire

//--- rtl/psi_if.sv
`default_nettype none
interface psi_if;
   logic sck;  // serial clock
   logic ws;   // word select
   logic sd;   // serial_audio_in data
   modport src (output sck, output ws, output sd);
   modport dev (input sck, input ws, input sd);
endinterface : psi_if
`default_nettype wire

//--- rtl/psi_rx.sv
// Implementation choice: a simple strobe port to the registers.
`include "psi_consts.svh"
`default_nettype none
module psi_rx
   import psi_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // serial link, receive only
   psi_if.dev               link,
   // control register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   // decoded audio
   output logic      [23:0] left_out,
   output logic      [23:0] right_out,
   output logic             pair_valid_out,
   output logic             frame_err_out
);

   // =====================================================
   // configuration registers
   logic [7:0] fmt_q;   // word format register
   logic [7:0] tim_q;   // bit timing register

   // written one byte per strobe
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fmt_q <= `PSI_RST_FORMAT;
         tim_q <= `PSI_RST_TIMING;
      end else if (reg_wr_in) begin
         // unmapped writes are dropped
         if (reg_addr_in == `PSI_REG_FORMAT) begin
            fmt_q <= reg_wdata_in;
         end else if (reg_addr_in == `PSI_REG_TIMING) begin
            tim_q <= reg_wdata_in;
         end
      end
   end

   // read data registered, one cycle after strobe
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `PSI_REG_FORMAT: reg_rdata_out <= fmt_q;
            `PSI_REG_TIMING: reg_rdata_out <= tim_q;
            default:         reg_rdata_out <= 8'h00;  // unmapped
         endcase
      end
   end

   // =====================================================
   // decoded settings
   psi_geom_s  geom;        // half length, start, width
   logic       right_first; // right word leads the pair
   logic       lsb_first;   // bit order
   logic       ws_pol;      // level of the first word
   logic       sck_pol;     // capture edge select

   assign geom        = psi_geom(fmt_q[`PSI_FMT_MSB:0],
                                 tim_q[`PSI_FSIZE_MSB:`PSI_FSIZE_LSB]); // RULE1 RULE3
   assign right_first = tim_q[`PSI_RIGHTFIRST_BIT];
   assign lsb_first   = tim_q[`PSI_LSBFIRST_BIT];
   assign ws_pol      = tim_q[`PSI_WSPOL_BIT];
   assign sck_pol     = tim_q[`PSI_SCKPOL_BIT];

   // =====================================================
   // pin synchronisers
   logic [2:0] pins;          // sd, ws, sck
   logic [2:0] sync_q [3];    // three stages per pin
   logic [2:0] filt_q;        // accepted pin levels

   assign pins = {link.sd, link.ws, link.sck};

   // per pin: a change counts once stages two and three agree
   for (genvar p = 0; p < 3; p++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            sync_q[p] <= 3'h0;
            filt_q[p] <= 1'b0;
         end else begin
            sync_q[p] <= {sync_q[p][1:0], pins[p]};
            if (sync_q[p][1] == sync_q[p][2]) begin
               filt_q[p] <= sync_q[p][2];
            end
         end
      end
   end

   // =====================================================
   // capture edge detection
   logic sck_last_q;  // previous accepted clock level
   logic cap;         // one cycle at the capture edge

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_last_q <= 1'b0;
      end else begin
         sck_last_q <= filt_q[0];
      end
   end

   // falling edge by default, rising when swapped
   assign cap = sck_pol ? (filt_q[0] & ~sck_last_q)
                        : (~filt_q[0] & sck_last_q); // RULE6

   // =====================================================
   // bit position tracking
   logic       ws_last_q;  // word select at last capture
   logic [5:0] idx_q;      // clock index in current half
   logic       armed_q;    // a word select change has been seen
   logic       ws_chg;     // word select moved
   logic [5:0] idx_n;      // index of this capture

   assign ws_chg = filt_q[1] != ws_last_q;
   assign idx_n  = ws_chg ? 6'h00 : idx_q + 6'h01;

   // index restarts on every word select change
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ws_last_q <= 1'b0;
         idx_q     <= 6'h00;
      end else if (cap) begin
         ws_last_q <= filt_q[1];
         idx_q     <= idx_n;
      end
   end

   // half length check; the first half after reset is partial
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         armed_q       <= 1'b0;
         frame_err_out <= 1'b0;
      end else if (cap && ws_chg) begin
         armed_q <= 1'b1;
         if (armed_q) begin
            frame_err_out <= (idx_q + 6'h01) != geom.half; // RULE3 RULE7
         end
      end
   end

   // =====================================================
   // word assembly
   logic        act_q;    // inside a word
   logic [4:0]  n_q;      // bits taken so far
   logic        slot_q;   // word select level of the word
   logic [23:0] sh_q;     // assembly register
   logic        begin_w;  // first bit of a word
   logic        take;     // this capture holds a data bit
   logic [4:0]  bitpos;   // bit number within the word
   logic [23:0] sh_d;     // assembly next value
   logic        done;     // last bit of the word
   logic        slot;     // level of the word just done

   // a word may run past the change in standard mode
   assign begin_w = idx_n == geom.start;
   assign take    = act_q | begin_w;
   assign bitpos  = begin_w ? 5'h00 : n_q;
   assign done    = take && ({1'b0, bitpos} + 6'h01 == geom.width);
   assign slot    = begin_w ? filt_q[1] : slot_q;

   // shift in msb first, or place bit by number lsb first
   always_comb begin
      sh_d = sh_q;
      if (begin_w) begin
         sh_d = {23'h000000, filt_q[2]};
      end else if (lsb_first) begin
         sh_d[bitpos] = filt_q[2]; // RULE4
      end else begin
         sh_d = {sh_q[22:0], filt_q[2]}; // RULE4
      end
   end

   // bit counting per word
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         act_q  <= 1'b0;
         n_q    <= 5'h00;
         slot_q <= 1'b0;
         sh_q   <= 24'h000000;
      end else if (cap && take) begin
         sh_q   <= sh_d;
         slot_q <= slot;
         n_q    <= bitpos + 5'h01;
         act_q  <= !done;
      end
   end

   // =====================================================
   // pairing of words
   logic [23:0] hold_q;  // first word of the pair
   logic        first;   // finished word leads the pair

   assign first = slot == ws_pol; // RULE5

   // output only once the second word completes the pair
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_q         <= 24'h000000;
         left_out       <= 24'h000000;
         right_out      <= 24'h000000;
         pair_valid_out <= 1'b0;
      end else begin
         pair_valid_out <= 1'b0;
         if (cap && done) begin
            if (first) begin
               hold_q <= sh_d;
            end else begin
               pair_valid_out <= 1'b1;
               if (right_first) begin
                  right_out <= hold_q; // RULE2
                  left_out  <= sh_d;
               end else begin
                  left_out  <= hold_q; // RULE2
                  right_out <= sh_d;
               end
            end
         end
      end
   end

endmodule : psi_rx
`default_nettype wire

//--- rtl/psi_tx.sv
`include "psi_consts.svh"
`default_nettype none
module psi_tx
   import psi_pkg::*;
#(
   parameter int HALF_DIV = 8  // system clocks per serial clock half
)(
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // serial link, master side
   psi_if.src               link
);

   // =====================================================
   // apb registers
   logic [16:0] cfg_q;    // enable, timing, format
   logic [23:0] pl_q;     // pending left word
   logic [23:0] pr_q;     // pending right word
   logic        pend_q;   // pair waiting for the link
   logic        ld;       // link takes the pending pair
   logic        acc;      // access phase, first cycle
   logic        wr;       // write takes effect
   logic        hit;      // mapped address

   assign acc = psel_in & penable_in & ~pready_out;
   assign wr  = psel_in & penable_in & pready_out & pwrite_in;
   assign hit = paddr_in == `PSI_APB_CFG || paddr_in == `PSI_APB_LEFT
             || paddr_in == `PSI_APB_RIGHT || paddr_in == `PSI_APB_STAT;

   // one wait state; read data ready with pready
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h00000000;
      end else begin
         pready_out  <= acc;
         pslverr_out <= acc & ~hit;
         if (acc) begin
            case (paddr_in)
               `PSI_APB_CFG:   prdata_out <= {15'h0000, cfg_q};
               `PSI_APB_LEFT:  prdata_out <= {8'h00, pl_q};
               `PSI_APB_RIGHT: prdata_out <= {8'h00, pr_q};
               `PSI_APB_STAT:  prdata_out <= {30'h00000000, cfg_q[16], pend_q};
               default:        prdata_out <= 32'h00000000;
            endcase
         end
      end
   end

   // writing right completes a pair; a new pair beats the take
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_q  <= {1'b0, `PSI_RST_TIMING, `PSI_RST_FORMAT};
         pl_q   <= 24'h000000;
         pr_q   <= 24'h000000;
         pend_q <= 1'b0;
      end else begin
         if (ld) begin
            pend_q <= 1'b0;
         end
         if (wr && paddr_in == `PSI_APB_CFG) begin
            cfg_q <= pwdata_in[16:0];
         end
         if (wr && paddr_in == `PSI_APB_LEFT) begin
            pl_q <= pwdata_in[23:0];
         end
         if (wr && paddr_in == `PSI_APB_RIGHT) begin
            pr_q   <= pwdata_in[23:0];
            pend_q <= 1'b1;
         end
      end
   end

   // =====================================================
   // serial clock divider
   psi_geom_s g;
   logic [7:0] tim;
   logic       en;
   logic [7:0] dcnt_q;   // divider count
   logic       launch;   // edge on which lines change

   assign tim = cfg_q[15:8];
   assign en  = cfg_q[`PSI_CFG_EN_BIT];
   assign g   = psi_geom(cfg_q[`PSI_FMT_MSB:0],
                         tim[`PSI_FSIZE_MSB:`PSI_FSIZE_LSB]); // RULE1 RULE3
   // rising edge launches by default, falling when swapped
   assign launch = en && dcnt_q == 8'(HALF_DIV - 1)
                && link.sck == tim[`PSI_SCKPOL_BIT]; // RULE6

   // idle level follows timing bit 0; the first toggle is a launch unless the write that sets enable also changes bit 0
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dcnt_q   <= 8'h00;
         link.sck <= 1'b0;
      end else if (!en) begin
         dcnt_q   <= 8'h00;
         link.sck <= tim[`PSI_SCKPOL_BIT];
      end else if (dcnt_q == 8'(HALF_DIV - 1)) begin
         dcnt_q   <= 8'h00;
         link.sck <= ~link.sck; // RULE7
      end else begin
         dcnt_q <= dcnt_q + 8'h01;
      end
   end

   // =====================================================
   // frame position and data lines
   logic        run_q;   // link running
   logic [6:0]  pos_q;   // clock within the frame
   logic [23:0] cl_q;    // left word on the wire
   logic [23:0] cr_q;    // right word on the wire
   logic [6:0]  pos_n;
   logic        hf;      // second half
   logic [5:0]  k;       // clock within the half
   logic        wh;      // word owning this clock
   logic [5:0]  d;       // data bit number
   logic [23:0] wl;
   logic [23:0] wr_w;
   logic [23:0] word;

   assign pos_n = !run_q ? 7'h00
                : (pos_q == {g.half, 1'b0} - 7'h01) ? 7'h00 : pos_q + 7'h01;
   assign hf    = pos_n >= {1'b0, g.half};
   assign k     = hf ? 6'(pos_n - {1'b0, g.half}) : pos_n[5:0];
   assign wh    = (k < g.start) ? ~hf : hf;
   assign d     = (k >= g.start) ? k - g.start : k + g.half - g.start;
   assign ld    = launch && pos_n == {1'b0, g.start} && pend_q;
   assign wl    = ld ? pl_q : cl_q;
   assign wr_w  = ld ? pr_q : cr_q;
   // first word of the pair is right when swapped
   assign word  = (wh ^ tim[`PSI_RIGHTFIRST_BIT]) ? wr_w : wl; // RULE2

   // lines change only on launch edges
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_q   <= 1'b0;
         pos_q   <= 7'h00;
         cl_q    <= 24'h000000;
         cr_q    <= 24'h000000;
         link.ws <= 1'b0;
         link.sd <= 1'b0;
      end else if (!en) begin
         run_q <= 1'b0;
      end else if (launch) begin
         run_q   <= 1'b1;
         pos_q   <= pos_n;
         link.ws <= hf ^ tim[`PSI_WSPOL_BIT]; // RULE5
         if (ld) begin
            cl_q <= pl_q;
            cr_q <= pr_q;
         end
         if (d >= g.width) begin
            link.sd <= 1'b0;
         end else if (tim[`PSI_LSBFIRST_BIT]) begin
            link.sd <= word[d[4:0]]; // RULE4
         end else begin
            link.sd <= word[5'(g.width - 6'h01 - d)]; // RULE4
         end
      end
   end

endmodule : psi_tx
`default_nettype wire

//--- verif/psi_chk.sv
`default_nettype none
module psi_chk (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // link lines
   input wire logic sck,
   input wire logic ws,
   input wire logic sd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // helper state
   logic       sck_q;    // last sck sample
   logic       ws_q;     // last ws sample
   logic [7:0] edges_q;  // sck edges since ws change
   logic [7:0] prev_q;   // edges of previous half
   logic [7:0] idle_q;   // clocks without sck edge
   logic [1:0] hn_q;     // ws changes seen, saturating
   logic       lvl_q;    // sck level on launch edges
   wire logic  sck_ch = sck ^ sck_q;
   wire logic  ws_ch = ws ^ ws_q;
   // the ws change count restarts once the link stops, so a new setup starts clean
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_q <= 1'b0;
         ws_q <= 1'b0;
         edges_q <= 8'h00;
         prev_q <= 8'h00;
         idle_q <= 8'h00;
         hn_q <= 2'h0;
         lvl_q <= 1'b0;
      end else begin
         sck_q <= sck;
         ws_q <= ws;
         idle_q <= sck_ch ? 8'h00 : (idle_q == 8'hff) ? idle_q : idle_q + 8'h01;
         if (sck_ch) begin
            edges_q <= ws_ch ? 8'h01 : edges_q + 8'h01;
         end
         if (ws_ch) begin
            prev_q <= edges_q;
            lvl_q <= sck;
         end
         if (idle_q > 8'h28) begin
            hn_q <= 2'h0;
         end else if (ws_ch && hn_q != 2'h3) begin
            hn_q <= hn_q + 2'h1;
         end
      end
   end
   // ==========
   // assertions
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // divider of eight system clocks per sck half
   AST_SCK_HALF: assert property ($changed(sck) |=> $stable(sck) [*7])
      else $error("sck half period too short");
   AST_WS_EDGE: assert property ($changed(ws) |-> $changed(sck))
      else $error("ws moved without an sck edge");
   AST_SD_EDGE: assert property ($changed(sd) |-> $changed(sck))
      else $error("sd moved without an sck edge");
   AST_SD_LAUNCH: assert property ($changed(sd) && hn_q != 2'h0 |-> sck == lvl_q)
      else $error("sd moved on the capture edge");
   AST_CAPTURE_QUIET: assert property (sck_ch && sck != lvl_q && hn_q != 2'h0
      |-> $stable(sd) && $stable(ws)) else $error("lines moved at capture");
   AST_HALF_LEN: assert property (ws_ch && hn_q != 2'h0
      |-> edges_q inside {8'h20, 8'h30, 8'h40}) else $error("bad half length");
   AST_HALF_EQUAL: assert property (ws_ch && hn_q > 2'h1 |-> edges_q == prev_q)
      else $error("halves of unequal length");
   AST_WS_HOLD: assert property ($rose(ws) || $fell(ws) |=> !ws_ch [*8])
      else $error("ws held too briefly");
   // main scenarios
   cover property (ws_ch && hn_q == 2'h3 && edges_q == 8'h40);
   cover property (ws_ch && hn_q == 2'h3 && edges_q == 8'h30);
   cover property (ws_ch && hn_q == 2'h3 && edges_q == 8'h20);
endmodule : psi_chk
`default_nettype wire

//--- verif/tb_pcm_serial_input_format.sv
`default_nettype none
module tb_pcm_serial_input_format;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // signals
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;  // reset from time zero
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic [23:0] left;
   logic [23:0] right;
   logic        pv;
   logic        ferr;   // frame length flag of the checked link
   logic        ferr2;  // error flag of the rule-breaking link
   int          n_fail = 0;
   int          comparisons = 0;
   // setups: format code and timing byte; last one uses spare codes
   localparam logic [2:0] FMT_T [8] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h2};
   localparam logic [7:0] TIM_T [8] = '{8'h00, 8'h0c, 8'h13, 8'h21, 8'h0a, 8'h24, 8'h11, 8'h18};
   // ==========
   // design
   psi_if lnk ();
   psi_if l2 ();
   psi_tx #(.HALF_DIV(8)) psi_tx_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .link(lnk.src));
   psi_rx psi_rx_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(lnk.dev),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .left_out(left), .right_out(right),
      .pair_valid_out(pv), .frame_err_out(ferr));
   // second receiver faces a bench driver that breaks the frame length
   psi_rx psi_rx_err_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .link(l2.dev),
      .reg_addr_in(8'h00), .reg_wdata_in(8'h00), .reg_wr_in(1'b0), .reg_rd_in(1'b0),
      .reg_rdata_out(), .left_out(), .right_out(), .pair_valid_out(),
      .frame_err_out(ferr2));
   psi_chk psi_chk_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sck(lnk.sck),
      .ws(lnk.ws), .sd(lnk.sd));
   initial begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   // ==========
   // tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic do_reset();
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
   endtask : do_reset
   // apb cycle: setup, then access held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      // wait states are the slave's; only the watchdog ends a hung wait
      do begin
         @(posedge clk_sys_in);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rreg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
   endtask : rreg_wr
   task automatic rreg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      @(posedge clk_sys_in);
      d = reg_rdata;
   endtask : rreg_rd
   // bounded wait for one pair pulse
   task automatic wait_pv();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pv !== 1'b1 && n < 3000);
      check(n < 3000, 1'b1);
   endtask : wait_pv
   // capture n bits off the wire from the ws change that opens the first word
   task automatic wire_word(input logic cp, input logic lvl, input int n,
                            output logic [63:0] b);
      logic pw;
      int   i;
      b = '0;
      i = -1;
      pw = lnk.ws;
      repeat (4000) begin
         if (cp) @(posedge lnk.sck); else @(negedge lnk.sck);
         if (i < 0 && lnk.ws === lvl && pw !== lvl) i = 0;
         if (i >= 0 && i < n) begin
            b[i] = lnk.sd;
            i++;
         end
         pw = lnk.ws;
         if (i == n) break;
      end
   endtask : wire_word
   // one setup end to end: wire layout and decoded pair
   task automatic t_cfg(input logic [2:0] f, input logic [7:0] t, input logic [23:0] sv);
      int          h, w, s;
      logic [23:0] m, lv, rv, fw;
      logic [63:0] b, e, bm;
      logic [31:0] r;
      logic        er;
      logic [7:0]  d;
      h = (t[4:3] == 2'h1) ? 24 : (t[4:3] == 2'h2) ? 16 : 32;
      case (f)
         3'h4: w = 16;
         3'h5: w = 20;
         3'h6: w = 18;
         3'h7: w = 24;
         default: w = (h > 24) ? 24 : h;
      endcase
      if (w > h) w = h;
      s = f[2] ? h - w : (f[0] ? 0 : 1);  // standard starts one clock late
      m = 24'hffffff >> (24 - w);
      lv = sv & m;
      rv = ~sv & m;
      fw = t[5] ? rv : lv;
      do_reset();  // setups change only while the link is stopped
      rreg_wr(8'h35, {5'h00, f});
      rreg_wr(8'h36, t);
      rreg_rd(8'h35, d);
      check(d, {5'h00, f});
      rreg_rd(8'h36, d);
      check(d, t);
      apb(1'b1, 8'h04, {8'h00, lv}, r, er);
      apb(1'b1, 8'h08, {8'h00, rv}, r, er);
      apb(1'b0, 8'h0c, 32'h0, r, er);
      check(r[1:0], 2'h1);
      apb(1'b1, 8'h00, {15'h0000, 1'b1, t, 5'h00, f}, r, er);
      wire_word(t[0], t[1], h + 1, b);
      e = '0;
      bm = '0;
      for (int k = 0; k < w; k++) begin
         bm[s + k] = 1'b1;
         e[s + k] = t[2] ? fw[k] : fw[w - 1 - k];
      end
      check(b & bm, e);
      wait_pv();
      wait_pv();
      check({left, right}, {lv, rv});
      check(ferr, 1'b0);
      $display("test setup fmt=%h tim=%h done", f, t);
   endtask : t_cfg
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      logic [7:0]  d;
      do_reset();
      rreg_rd(8'h35, d);
      check(d, 8'h01);
      rreg_rd(8'h36, d);
      check(d, 8'h01);
      rreg_rd(8'h37, d);
      check(d, 8'h00);
      apb(1'b0, 8'h00, 32'h0, r, e);
      check({e, r}, 33'h000000101);
      apb(1'b1, 8'h10, 32'h1, r, e);
      check(e, 1'b1);
      $display("test reset done");
   endtask : t_reset
   // free-running 125 ns link clock, lines move on its falling edge
   task automatic drv2(input int len, input int halves);
      #0.25;  // keeps every link edge off the system clock edges
      repeat (halves) begin
         for (int i = 0; i < len; i++) begin
            #62.5 l2.sck = 1'b1;
            #62.5 l2.sck = 1'b0;
            l2.sd = ~l2.sd;
            if (i == len - 1) l2.ws = ~l2.ws;
         end
      end
      repeat (10) @(posedge clk_sys_in);
   endtask : drv2
   task automatic t_err();
      drv2(32, 3);
      check(ferr2, 1'b0);
      drv2(10, 3);
      check(ferr2, 1'b1);
      drv2(32, 3);
      check(ferr2, 1'b0);
      $display("test frame length done");
   endtask : t_err
   task automatic test_done();
      $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   // ==========
   // sequence and watchdog
   initial begin
      l2.sck = 1'b0;  // idle link stands still
      l2.ws = 1'b0;
      l2.sd = 1'b0;
      t_reset();
      for (int i = 0; i < 8; i++) begin
         t_cfg(FMT_T[i], TIM_T[i], 24'(24'h9c35a7 ^ (24'h011111 * i)));
      end
      t_err();
      test_done();
   end
   initial begin
      repeat (90000) @(posedge clk_sys_in);
      n_fail++;
      test_done();
   end
endmodule : tb_pcm_serial_input_format
`default_nettype wire
